// [design/ecl_pkg.sv]
package ecl_pkg;

    // Load sequencer states
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_LOAD = 2'b10,
        ST_DONE = 2'b11
    } ecl_state_e;

    // One word delivered by the serial EEPROM reader
    typedef struct packed
    {
        logic        valid;
        logic [7:0]  addr;
        logic [15:0] data;
    } ecl_word_s;

    // Loaded configuration fields of one port
    typedef struct packed
    {
        logic       keep_state;
        logic [2:0] aux_cur;
        logic       d1_sup;
        logic       d2_sup;
        logic [1:0] pme_sup;
        logic [7:0] pm_data;
        logic       slot_impl;
        logic       conn_clk;
        logic       dsi_req;
        logic       lpvc_vc1;
        logic [2:0] port_num;
        logic [6:0] tc_map;
    } ecl_cfg_s;

    localparam ecl_cfg_s CFG_RST = '{default: '0, d1_sup: 1'b1, d2_sup: 1'b1};

    // EEPROM word addresses per port (A: main word, B: data-byte word)
    localparam logic [3:0][7:0] EE_WORD_A = {8'h56, 8'h54, 8'h62, 8'h60};
    localparam logic [3:0][7:0] EE_WORD_B = {8'h57, 8'h55, 8'h00, 8'h00};

    // Bit positions inside an EEPROM word
    localparam int EE_KEEP_BIT = 0;
    localparam int EE_AUX_LSB  = 1;
    localparam int EE_D1_BIT   = 4;
    localparam int EE_D2_BIT   = 5;
    localparam int EE_PME_LSB  = 6;
    localparam int EE_PMD_LSB  = 8;
    localparam int EE_SLOT_BIT = 0;
    localparam int EE_CLK_BIT  = 1;
    localparam int EE_DSI_BIT  = 2;
    localparam int EE_LPVC_BIT = 3;
    localparam int EE_PNUM_LSB = 4;
    localparam int EE_TC_LSB   = 9;

    // Bit positions inside the configuration space words
    localparam int POS_KEEP = 3;
    localparam int POS_AUX  = 22;
    localparam int POS_D1   = 25;
    localparam int POS_D2   = 26;
    localparam int POS_PME  = 28;
    localparam int POS_PMD  = 24;
    localparam int POS_DSI  = 21;
    localparam int POS_SLOT = 24;
    localparam int POS_CLK  = 28;
    localparam int POS_PNUM = 24;
    localparam int POS_LPVC = 4;
    localparam int POS_TC   = 1;

    // Wishbone map: ADR[6:5] port, ADR[4:2] config word selector
    localparam logic [2:0] SEL_CFG40  = 3'h0;
    localparam logic [2:0] SEL_CFG44  = 3'h1;
    localparam logic [2:0] SEL_CFGC0  = 3'h2;
    localparam logic [2:0] SEL_CFGCC  = 3'h3;
    localparam logic [2:0] SEL_CFGD0  = 3'h4;
    localparam logic [2:0] SEL_CFG144 = 3'h5;
    localparam logic [2:0] SEL_CFG154 = 3'h6;
    localparam logic [7:0] ADR_CTRL   = 8'h80;
    localparam logic [7:0] ADR_STAT   = 8'h84;
    localparam int         CTRL_RELOAD_BIT = 0;

endpackage : ecl_pkg

// [design/ecl_loader.sv]
module ecl_loader
    import ecl_pkg::*;
(
    input  wire logic            CLOCK_I,
    input  wire logic            RSTN_I,
    input  wire ecl_word_s       EE_WORD_I,
    input  wire logic            EE_DONE_I,
    output logic                 EE_LOAD_REQ_O,
    output logic                 LOAD_DONE_O,
    output ecl_cfg_s [3:0]       PORT_CFG_O,
    input  wire logic            WB_CYC_I,
    input  wire logic            WB_STB_I,
    input  wire logic            WB_WE_I,
    input  wire logic [7:0]      WB_ADR_I,
    input  wire logic [3:0]      WB_SEL_I,
    input  wire logic [31:0]     WB_DAT_I,
    output logic [31:0]          WB_DAT_O,
    output logic                 WB_ACK_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_m_q;
    logic rst_n;

    // Two stages so release never lands mid-setup
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            rst_m_q <= 1'b0;
            rst_n   <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_n   <= rst_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Load sequencer
    ecl_state_e st_q;
    ecl_state_e st_d;
    logic       req_q;
    logic       req_d;
    logic       reload;
    logic       take;
    logic       done_q;
    logic       done_d;

    assign take = (st_q == ST_LOAD) && EE_WORD_I.valid;

    // Request the reader once, then accept words until it reports the end
    always_comb
    begin
        st_d  = st_q;
        req_d = 1'b0;
        case (st_q)
            ST_IDLE: st_d = ST_REQ;
            ST_REQ:
            begin
                req_d = 1'b1;
                st_d  = ST_LOAD;
            end
            ST_LOAD: if (EE_DONE_I) st_d = ST_DONE;
            ST_DONE: if (reload) st_d = ST_REQ;
            default: st_d = ST_IDLE;
        endcase
        done_d = (st_d == ST_DONE);
    end

    always_ff @(posedge CLOCK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q   <= ST_IDLE;
            req_q  <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            req_q  <= req_d;
            done_q <= done_d;
        end
    end

    assign EE_LOAD_REQ_O = req_q;

    ////////////////////////////////////////////////////////////////////////////
    // Per-port field capture
    ecl_cfg_s [3:0] cfg_q;
    ecl_cfg_s [3:0] cfg_d;

    for (genvar p = 0; p < 4; p++)
    begin : g_port
        // Power-management words for ports 2 and 3, link words for 0 and 1
        always_comb
        begin
            cfg_d[p] = cfg_q[p];
            if (p >= 2)
            begin
                if (take && EE_WORD_I.addr == EE_WORD_A[p])
                begin
                    cfg_d[p].keep_state = EE_WORD_I.data[EE_KEEP_BIT];
                    cfg_d[p].aux_cur    = EE_WORD_I.data[EE_AUX_LSB +: 3];
                    cfg_d[p].d1_sup     = EE_WORD_I.data[EE_D1_BIT];
                    cfg_d[p].d2_sup     = EE_WORD_I.data[EE_D2_BIT];
                    cfg_d[p].pme_sup    = EE_WORD_I.data[EE_PME_LSB +: 2];
                end
                if (take && EE_WORD_I.addr == EE_WORD_B[p])
                    cfg_d[p].pm_data = EE_WORD_I.data[EE_PMD_LSB +: 8];
            end
            else if (take && EE_WORD_I.addr == EE_WORD_A[p])
            begin
                if (p == 1)
                    cfg_d[p].slot_impl = EE_WORD_I.data[EE_SLOT_BIT];
                cfg_d[p].conn_clk = EE_WORD_I.data[EE_CLK_BIT];
                cfg_d[p].dsi_req  = EE_WORD_I.data[EE_DSI_BIT];
                cfg_d[p].lpvc_vc1 = EE_WORD_I.data[EE_LPVC_BIT];
                cfg_d[p].port_num = EE_WORD_I.data[EE_PNUM_LSB +: 3];
                cfg_d[p].tc_map   = EE_WORD_I.data[EE_TC_LSB +: 7];
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n)
    begin
        if (!rst_n)
            cfg_q <= {4{CFG_RST}};
        else
            cfg_q <= cfg_d;
    end

    assign PORT_CFG_O  = cfg_q;
    // Flopped copy of the done state keeps the output free of decode glitches
    assign LOAD_DONE_O = done_q;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    logic        ack_q;
    logic        ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic        req;
    logic        is_port;
    ecl_cfg_s    c;

    assign req     = WB_CYC_I && WB_STB_I && !ack_q;
    assign is_port = !WB_ADR_I[7];
    assign c       = cfg_q[WB_ADR_I[6:5]];
    assign reload  = req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ADR_CTRL
                     && WB_DAT_I[CTRL_RELOAD_BIT];

    // Port words hold off until loading ends so software never sees defaults
    always_comb
    begin
        ack_d = req && (!is_port || st_q == ST_DONE);
        dat_d = 32'h0000_0000;
        if (is_port && !WB_WE_I)
        begin
            case (WB_ADR_I[4:2])
                SEL_CFG40:  dat_d = (32'(c.aux_cur) << POS_AUX) | (32'(c.d1_sup) << POS_D1)
                                  | (32'(c.d2_sup) << POS_D2) | (32'(c.pme_sup) << POS_PME)
                                  | (32'(c.dsi_req) << POS_DSI);
                SEL_CFG44:  dat_d = (32'(c.keep_state) << POS_KEEP) | (32'(c.pm_data) << POS_PMD);
                SEL_CFGC0:  dat_d = 32'(c.slot_impl) << POS_SLOT;
                SEL_CFGCC:  dat_d = 32'(c.port_num) << POS_PNUM;
                SEL_CFGD0:  dat_d = 32'(c.conn_clk) << POS_CLK;
                SEL_CFG144: dat_d = 32'(c.lpvc_vc1) << POS_LPVC;
                SEL_CFG154: dat_d = 32'(c.tc_map) << POS_TC;
                default:    dat_d = 32'h0000_0000;
            endcase
        end
        else if (!WB_WE_I && WB_ADR_I == ADR_STAT)
            dat_d = {30'h0000_0000, st_q == ST_LOAD, st_q == ST_DONE};
    end

    always_ff @(posedge CLOCK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [15:0] wd;
    logic [7:0]  wa;
    assign wd = EE_WORD_I.data;
    assign wa = EE_WORD_I.addr;

    AST_R1: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h54 |=> cfg_q[2].keep_state == $past(wd[0]))
        else $error("Port 2 keep-state not loaded");
    AST_R2: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h54 |=> cfg_q[2].aux_cur == $past(wd[3:1]))
        else $error("Port 2 aux current not loaded");
    AST_R3: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h54 |=> cfg_q[2].d1_sup == $past(wd[4]))
        else $error("Port 2 D1 flag not loaded");
    AST_R4: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h56 |=> cfg_q[3].d2_sup == $past(wd[5]))
        else $error("Port 3 D2 flag not loaded");
    AST_R5: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h54 |=> cfg_q[2].pme_sup == $past(wd[7:6]) && $stable(cfg_q[3]))
        else $error("Port 2 wake support wrong or port 3 disturbed");
    AST_R6: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h55 |=> cfg_q[2].pm_data == $past(wd[15:8]))
        else $error("Port 2 data byte not loaded");
    AST_R7: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h56 |=> {cfg_q[3].aux_cur, cfg_q[3].keep_state} == $past(wd[3:0]))
        else $error("Port 3 capability not loaded");
    AST_R8: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h57 |=> cfg_q[3].pm_data == $past(wd[15:8]))
        else $error("Port 3 data byte not loaded");
    AST_R9: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h60 |=> cfg_q[0].conn_clk == $past(wd[1]))
        else $error("Port 0 clock flag not loaded");
    AST_R10: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h60 |=> cfg_q[0].dsi_req == $past(wd[2]))
        else $error("Port 0 init flag not loaded");
    AST_R11: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h60 |=> cfg_q[0].lpvc_vc1 == $past(wd[3]))
        else $error("Port 0 channel flag not loaded");
    AST_R12: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h60 |=> cfg_q[0].port_num == $past(wd[6:4]))
        else $error("Port 0 port number not loaded");
    AST_R13: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h60 |=> cfg_q[0].tc_map == $past(wd[15:9]))
        else $error("Port 0 class map not loaded");
    AST_R14: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h62 |=> cfg_q[1].slot_impl == $past(wd[0]) && !cfg_q[0].slot_impl)
        else $error("Port 1 slot flag not loaded");
    AST_R15: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h62 |=> {cfg_q[1].tc_map, cfg_q[1].port_num, cfg_q[1].lpvc_vc1,
                                 cfg_q[1].dsi_req, cfg_q[1].conn_clk} == {$past(wd[15:9]), $past(wd[6:1])})
        else $error("Port 1 link fields not loaded");
    AST_R16: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        WB_ACK_O && !$past(WB_ADR_I[7]) |-> $past(st_q) == ST_DONE ##1 !WB_ACK_O)
        else $error("Port word answered before load done");

    // Port 3 layout matches port 2; a word for one port never touches another
    AST_R2_P3: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h56 |=> cfg_q[3].aux_cur == $past(wd[3:1]))
        else $error("Port 3 aux current not loaded");
    AST_R3_P3: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h56 |=> cfg_q[3].d1_sup == $past(wd[4]))
        else $error("Port 3 D1 flag not loaded");
    AST_R4_P2: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h54 |=> cfg_q[2].d2_sup == $past(wd[5]))
        else $error("Port 2 D2 flag not loaded");
    AST_R5_P3: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h56 |=> cfg_q[3].pme_sup == $past(wd[7:6]))
        else $error("Port 3 wake support not loaded");
    AST_R15_ISO: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        take && wa == 8'h60 |=> $stable(cfg_q[1]) && $stable(cfg_q[2]) && $stable(cfg_q[3]))
        else $error("Port 0 word disturbed another port");

    // Handshake shape: stall while loading, single-cycle request, clean restart
    AST_R16_STALL: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        WB_CYC_I && WB_STB_I && !WB_ADR_I[7] && !LOAD_DONE_O |=> !WB_ACK_O)
        else $error("Port word acknowledged while loading");
    AST_R16_DONE: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        st_q == ST_LOAD && EE_DONE_I |=> LOAD_DONE_O && !EE_LOAD_REQ_O)
        else $error("Load end not flagged");
    AST_R16_RELOAD: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        reload && LOAD_DONE_O |=> !LOAD_DONE_O ##1 EE_LOAD_REQ_O)
        else $error("Reload did not restart the reader");
    AST_REQ_PULSE: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        EE_LOAD_REQ_O |=> !EE_LOAD_REQ_O)
        else $error("Load request longer than one cycle");

    COV_LOAD:   cover property (@(posedge CLOCK_I) disable iff (!rst_n) take && wa == 8'h54);
    COV_DONE:   cover property (@(posedge CLOCK_I) disable iff (!rst_n) st_q == ST_LOAD ##1 st_q == ST_DONE);
    COV_READ:   cover property (@(posedge CLOCK_I) disable iff (!rst_n) WB_ACK_O && !WB_WE_I && !WB_ADR_I[7]);
    COV_RELOAD: cover property (@(posedge CLOCK_I) disable iff (!rst_n) reload);
    COV_STALL:  cover property (@(posedge CLOCK_I) disable iff (!rst_n) WB_CYC_I && WB_STB_I && !LOAD_DONE_O);

endmodule : ecl_loader

// [testbench/ecl_ee_model.sv]
module ecl_ee_model
    import ecl_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              req_i,
    input  wire logic              slow_i,
    input  wire logic [5:0][15:0]  words_i,
    output ecl_word_s              word_o,
    output logic                   done_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Last entry is a stray address that the loader must ignore
    localparam logic [6:0][7:0] ADRS = {8'h58, 8'h57, 8'h56, 8'h55, 8'h54, 8'h62, 8'h60};

    ////////////////////////////////////////////////////////////////
    // Word delivery after each load request
    initial
    begin
        word_o = '0;
        done_o = 1'h0;
        forever
        begin
            @(posedge clk_i);
            if (req_i === 1'h1)
            begin
                for (int i = 0; i < 7; i++)
                begin
                    // Slow reader: idle gaps with a toggling bus
                    repeat (slow_i ? 3 : 0)
                    begin
                        word_o.valid <= 1'h0;
                        word_o.data  <= ~word_o.data;
                        @(posedge clk_i);
                    end
                    word_o <= '{valid: 1'h1, addr: ADRS[i], data: (i == 6) ? ~words_i[0] : words_i[i]};
                    @(posedge clk_i);
                end
                // Stale data never looks valid
                word_o.valid <= 1'h0;
                word_o.data  <= ~word_o.data;
                done_o <= 1'h1;
                @(posedge clk_i);
                done_o <= 1'h0;
            end
        end
    end

endmodule : ecl_ee_model

// [testbench/test_ecl_loader.sv]
module test_ecl_loader;
    import ecl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk;
    logic              rstn;
    logic              cyc;
    logic              stb;
    logic              we;
    logic [7:0]        adr;
    logic [3:0]        sel;
    logic [31:0]       wdat;
    logic [31:0]       rdat;
    logic [31:0]       rd;
    logic              ack;
    logic              ld_req;
    logic              ld_done;
    logic              slow;
    logic              ee_done;
    ecl_word_s         ee_word;
    ecl_cfg_s [3:0]    cfg;
    logic [5:0][15:0]  ee;
    int                fails;
    int                samples_checked;
    int                cycles;
    int                seed;
    int                req_seen;

    ecl_loader ecl_loader_i (.CLOCK_I(clk), .RSTN_I(rstn), .EE_WORD_I(ee_word), .EE_DONE_I(ee_done),
        .EE_LOAD_REQ_O(ld_req), .LOAD_DONE_O(ld_done), .PORT_CFG_O(cfg), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));

    ecl_ee_model ecl_ee_model_i (.clk_i(clk), .req_i(ld_req), .slow_i(slow), .words_i(ee),
        .word_o(ee_word), .done_o(ee_done));

    ////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            $display("BAD t=%0t run timed out", $time);
            finish_test();
        end
    end

    // Counts reader requests so a lost or doubled load shows up
    always @(posedge clk)
        if (ld_req === 1'h1)
            req_seen <= req_seen + 1;

    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////
    // Classic Wishbone single cycle; waits for ack under a bound
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hF;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 3000);
        rd = rdat;
        if (n >= 3000)
        begin
            fails++;
            $display("BAD t=%0t no ack at adr %h", $time, a);
        end
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb

    task chk(input logic [31:0] got, input logic [31:0] exp, input logic [7:0] a);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t adr %h got %h want %h", $time, a, got, exp);
        end
    endtask : chk

    // Expected config word image; ee order 60h 62h 54h 55h 56h 57h
    function automatic logic [31:0] exp_word(int p, int s);
        logic [15:0] a;
        logic [15:0] b;
        logic [31:0] r;
        a = ee[(p < 2) ? p : (p == 2) ? 2 : 4];
        b = ee[(p == 2) ? 3 : 5];
        r = '0;
        if (p < 2)
        begin
            case (s)
                0: r[26:25] = 2'h3;
                2: r[24] = (p == 1) & a[0];
                3: r[26:24] = a[6:4];
                4: r[28] = a[1];
                5: r[4] = a[3];
                6: r[7:1] = a[15:9];
                default: r = '0;
            endcase
            if (s == 0)
                r[21] = a[2];
        end
        else if (s == 0)
            r = {2'h0, a[7:6], 1'h0, a[5], a[4], a[3:1], 22'h0};
        else if (s == 1)
            r = {b[15:8], 20'h0, a[0], 3'h0};
        return r;
    endfunction : exp_word

    ////////////////////////////////////////////////////////////////
    // Main sequence: four loads, corner words first, then random
    initial
    begin
        seed = 95;
        {cyc, stb, we, adr, sel, wdat, fails, samples_checked, cycles} = '0;
        slow = 1'h0;
        ee = {6{16'hFFFF}};
        rstn = 1'h0;
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        for (int t = 0; t < 4; t++)
        begin
            if (t > 0)
            begin
                for (int k = 0; k < 6; k++)
                    ee[k] = (t == 1) ? 16'h0 : 16'($random(seed));
                slow = t[0];
                wb(1'h1, ADR_CTRL, 32'h1);
                for (int n = 0; n < 10 && ld_done === 1'h1; n++)
                    @(posedge clk);
            end
            // First read is issued while loading and must see loaded values
            for (int p = 0; p < 4; p++)
                for (int s = 0; s < 8; s++)
                begin
                    wb(1'h0, {1'h0, 2'(p), 3'(s), 2'h0}, '0);
                    chk(rd, exp_word(p, s), adr);
                    chk(rd, exp_word(p, s), adr);
                end
            // Direct view of the loaded fields, not only through the bus
            chk(32'(cfg[1].tc_map), 32'(ee[1][15:9]), 8'h00);
            chk(32'(cfg[3].pm_data), 32'(ee[5][15:8]), 8'h00);
            chk(32'(ld_done), 32'h1, ADR_STAT);
            // Write to a port word is ignored
            wb(1'h1, 8'h40, 32'hFFFFFFFF);
            wb(1'h0, 8'h40, '0);
            chk(rd, exp_word(2, 0), adr);
            wb(1'h0, ADR_STAT, '0);
            chk({30'h0, rd[1:0]}, 32'h1, adr);
            wb(1'h0, 8'h88, '0);
            chk(rd, 32'h0, adr);
            $display("test %0d done", t);
        end
        chk(32'(req_seen), 32'h4, ADR_CTRL);
        finish_test();
    end

endmodule : test_ecl_loader
